// ---- pkg/snh_params.svh ----
`ifndef SNH_PARAMS_SVH
`define SNH_PARAMS_SVH

// clock rates and serial clock half period
`define SNH_SYS_NS    5
`define SNH_HALF_NS   20
`define SNH_HALF_CYC  (((`SNH_HALF_NS) + (`SNH_SYS_NS) - 1) / (`SNH_SYS_NS))
`define SNH_GAP_TICKS 4'h4

// opcodes
`define SNH_OP_RDC    8'h03
`define SNH_OP_FRDC   8'h0B
`define SNH_OP_RDC2   8'h3B
`define SNH_OP_RDC4   8'h6B
`define SNH_OP_RDCD   8'hBB
`define SNH_OP_RDCQ   8'hEB
`define SNH_OP_RDID   8'h9F
`define SNH_OP_SERN   8'h4B
`define SNH_OP_GETF   8'h0F
`define SNH_OP_SETF   8'h1F
`define SNH_OP_LD     8'h02
`define SNH_OP_LD4    8'h32
`define SNH_OP_RLD    8'h84
`define SNH_OP_RLD4   8'hC4
`define SNH_OP_RLD4B  8'h34
`define SNH_OP_RLDQ   8'h72
`define SNH_OP_PGRD   8'h13
`define SNH_OP_PEX    8'h10
`define SNH_OP_ERS    8'hD8
`define SNH_OP_WEN    8'h06
`define SNH_OP_WDIS   8'h04
`define SNH_OP_RST    8'hFF

// status feature, column limit, row layout
`define SNH_STAT_ADR  24'h0000C0
`define SNH_OPERATION_IN_PROGRESS 0
`define SNH_COL_MAX   12'h83F
`define SNH_SERN_DUM  5'h08
`define SNH_PG_W      6

`endif

// ---- pkg/snh_pkg.sv ----
package snh_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_CSHI} snh_st_e;
    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUM, PH_DATA, PH_END} snh_ph_e;
    // per-opcode frame shape, widths as log2 of line count
    typedef struct packed {
        logic       ok;
        logic [4:0] ab;
        logic [1:0] awl;
        logic [4:0] dc;
        logic [1:0] dwl;
        logic       rd;
        logic       dat;
        logic       qd;
        logic       bsy;
    } snh_op_s;
endpackage

// ---- pkg/snh_buf_if.sv ----
interface snh_buf_if;
    logic       in_valid;
    logic       in_ready;
    logic [7:0] in_data;
    logic       out_valid;
    logic       out_ready;
    logic [7:0] out_data;
    modport src  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// ---- core/snh_buf.sv ----
module snh_buf (
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    snh_buf_if.fifo     q
);
    logic [7:0] mem_r [2];
    logic [7:0] mem_nxt [2];
    logic       wp_r;
    logic       wp_nxt;
    logic       rp_r;
    logic       rp_nxt;
    logic [1:0] n_r;
    logic [1:0] n_nxt;
    logic       push;
    logic       pop;

    // honest full and empty flags
    assign q.in_ready  = n_r != 2'h2;
    assign q.out_valid = n_r != 2'h0;
    assign q.out_data  = mem_r[rp_r];
    assign push        = q.in_valid && q.in_ready;
    assign pop         = q.out_valid && q.out_ready;

    // pointer and occupancy update
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        if (push) begin
            mem_nxt[wp_r] = q.in_data;
            wp_nxt        = !wp_r;
        end
        if (pop) begin
            rp_nxt = !rp_r;
        end
        n_nxt = n_r + {1'h0, push} - {1'h0, pop};
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r[0] <= 8'h00;
            mem_r[1] <= 8'h00;
            wp_r     <= 1'h0;
            rp_r     <= 1'h0;
            n_r      <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            n_r   <= n_nxt;
        end
    end
endmodule

// ---- core/snh_ctrl.sv ----
`include "snh_params.svh"
module snh_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_op,
    input  wire logic [23:0] cmd_addr,
    input  wire logic [11:0] cmd_len,
    input  wire logic        quad_lines_enable,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [7:0]  wr_data,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [7:0]       rd_data,
    output logic             done,
    output logic             err,
    output logic [7:0]       status,
    output logic             sclk,
    output logic             cs_n,
    output logic [3:0]       io_o,
    output logic [3:0]       io_oe_n,
    input  wire logic [3:0]  io_i
);
    snh_pkg::snh_st_e st_r, st_nxt;
    snh_pkg::snh_ph_e ph_r, ph_nxt, np;
    snh_pkg::snh_op_s inf, cinf;
    logic [7:0]  op_r, op_nxt, rx_r, rx_nxt, stat_r, stat_nxt, sop;
    logic [23:0] addr_r, addr_nxt;
    logic [11:0] len_r, len_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [3:0]  div_r, div_nxt, gap_r, gap_nxt, s1_r, s2_r;
    logic [16:0] lr_r, lr_nxt;
    logic        sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, ld_r, ld_nxt;
    logic        poll_r, poll_nxt, wen_r, wen_nxt, lrv_r, lrv_nxt;
    logic        done_r, done_nxt, err_r, err_nxt;
    logic        tick, take, bad, ord_bad, push, drv;
    logic [1:0]  wl;

    // frame shape of each opcode
    function automatic snh_pkg::snh_op_s dec(input logic [7:0] op);
        unique case (op)
            `SNH_OP_RDC, `SNH_OP_FRDC: dec = '{1'h1, 5'h10, 2'h0, 5'h08, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0};
            `SNH_OP_RDC2:              dec = '{1'h1, 5'h10, 2'h0, 5'h08, 2'h1, 1'h1, 1'h1, 1'h0, 1'h0};
            `SNH_OP_RDC4:              dec = '{1'h1, 5'h10, 2'h0, 5'h08, 2'h2, 1'h1, 1'h1, 1'h1, 1'h0};
            `SNH_OP_RDCD:              dec = '{1'h1, 5'h10, 2'h1, 5'h04, 2'h1, 1'h1, 1'h1, 1'h0, 1'h0};
            `SNH_OP_RDCQ:              dec = '{1'h1, 5'h10, 2'h2, 5'h02, 2'h2, 1'h1, 1'h1, 1'h1, 1'h0};
            `SNH_OP_RDID, `SNH_OP_GETF: dec = '{1'h1, 5'h08, 2'h0, 5'h00, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0};
            `SNH_OP_SERN:              dec = '{1'h1, 5'h18, 2'h0, `SNH_SERN_DUM, 2'h0, 1'h1, 1'h1, 1'h0, 1'h0};
            `SNH_OP_SETF:              dec = '{1'h1, 5'h08, 2'h0, 5'h00, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0};
            `SNH_OP_LD, `SNH_OP_RLD:   dec = '{1'h1, 5'h10, 2'h0, 5'h00, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0};
            `SNH_OP_LD4, `SNH_OP_RLD4, `SNH_OP_RLD4B:
                                       dec = '{1'h1, 5'h10, 2'h0, 5'h00, 2'h2, 1'h0, 1'h1, 1'h1, 1'h0};
            `SNH_OP_RLDQ:              dec = '{1'h1, 5'h10, 2'h2, 5'h00, 2'h2, 1'h0, 1'h1, 1'h1, 1'h0};
            `SNH_OP_PGRD, `SNH_OP_PEX, `SNH_OP_ERS:
                                       dec = '{1'h1, 5'h18, 2'h0, 5'h00, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1};
            `SNH_OP_WEN, `SNH_OP_WDIS: dec = '{1'h1, 5'h00, 2'h0, 5'h00, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0};
            `SNH_OP_RST:               dec = '{1'h1, 5'h00, 2'h0, 5'h00, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1};
            default:                   dec = '0;
        endcase
    endfunction

    // serial clocks per phase (per byte in the data phase)
    function automatic logic [4:0] pclk(input snh_pkg::snh_ph_e p, input snh_pkg::snh_op_s i);
        unique case (p)
            snh_pkg::PH_CMD:  pclk = 5'h08;
            snh_pkg::PH_ADDR: pclk = i.ab >> i.awl;
            snh_pkg::PH_DUM:  pclk = i.dc;
            snh_pkg::PH_DATA: pclk = 5'h08 >> i.dwl;
            snh_pkg::PH_END:  pclk = 5'h01;
        endcase
    endfunction

    // next non-empty phase
    function automatic snh_pkg::snh_ph_e nph(input snh_pkg::snh_ph_e p, input snh_pkg::snh_op_s i,
                                             input logic [11:0] n);
        nph = snh_pkg::PH_END;
        if (p == snh_pkg::PH_CMD && i.ab != 5'h00) begin
            nph = snh_pkg::PH_ADDR;
        end else if (p <= snh_pkg::PH_ADDR && i.dc != 5'h00) begin
            nph = snh_pkg::PH_DUM;
        end else if (p <= snh_pkg::PH_DUM && i.dat && n != 12'h000) begin
            nph = snh_pkg::PH_DATA;
        end
    endfunction

    // two-entry read buffer
    snh_buf_if bif ();
    snh_buf u_buf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .q       (bif.fifo)
    );
    assign bif.in_valid  = push;
    assign bif.in_data   = rx_nxt;
    assign bif.out_ready = rd_ready;
    assign rd_valid      = bif.out_valid;
    assign rd_data       = bif.out_data;

    // decode and command checks
    assign inf       = dec(op_r);
    assign cinf      = dec(cmd_op);
    assign tick      = div_r == 4'h0;
    assign cmd_ready = st_r == snh_pkg::ST_IDLE && !poll_r;
    assign take      = cmd_valid && cmd_ready;
    assign sop       = poll_r ? `SNH_OP_GETF : cmd_op;
    assign np        = nph(ph_r, inf, len_r);
    assign ord_bad   = lrv_r && cmd_addr[16:`SNH_PG_W] == lr_r[16:`SNH_PG_W]
                     && cmd_addr[`SNH_PG_W-1:0] <= lr_r[`SNH_PG_W-1:0];
    assign bad       = !cinf.ok
                     || (cinf.qd && !quad_lines_enable)
                     || ((cmd_op == `SNH_OP_PEX || cmd_op == `SNH_OP_ERS) && !wen_r)
                     || (cmd_op == `SNH_OP_PEX && ord_bad)
                     || (cinf.ab == 5'h10 && cmd_addr[11:0] > `SNH_COL_MAX);
    assign done      = done_r;
    assign err       = err_r;
    assign status    = stat_r;
    assign sclk      = sclk_r;
    assign cs_n      = cs_n_r;

    // pin drive by phase width; io2/io3 held high below quad width, all lines released outside ST_SHIFT
    always_comb begin
        unique case (ph_r)
            snh_pkg::PH_ADDR: wl = inf.awl;
            snh_pkg::PH_DATA: wl = inf.dwl;
            default:          wl = 2'h0;
        endcase
        drv = st_r == snh_pkg::ST_SHIFT && (ph_r == snh_pkg::PH_CMD || ph_r == snh_pkg::PH_ADDR
              || (ph_r == snh_pkg::PH_DATA && !inf.rd));
        unique case (wl)
            2'h0: begin
                io_o    = {2'h3, 1'h0, sh_r[31]};
                io_oe_n = {2'h0, 1'h1, !drv};
            end
            2'h1: begin
                io_o    = {2'h3, sh_r[31:30]};
                io_oe_n = {2'h0, {2{!drv}}};
            end
            default: begin
                io_o    = sh_r[31:28];
                io_oe_n = {4{!drv}};
            end
        endcase
        if (st_r != snh_pkg::ST_SHIFT) begin
            io_oe_n = 4'hF;
        end
    end

    // frame sequencer
    always_comb begin
        st_nxt   = st_r;
        ph_nxt   = ph_r;
        op_nxt   = op_r;
        addr_nxt = addr_r;
        len_nxt  = len_r;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        rx_nxt   = rx_r;
        stat_nxt = stat_r;
        gap_nxt  = gap_r;
        lr_nxt   = lr_r;
        sclk_nxt = sclk_r;
        cs_n_nxt = cs_n_r;
        ld_nxt   = ld_r;
        poll_nxt = poll_r;
        wen_nxt  = wen_r;
        lrv_nxt  = lrv_r;
        done_nxt = 1'h0;
        err_nxt  = 1'h0;
        push     = 1'h0;
        wr_ready = 1'h0;
        div_nxt  = tick ? 4'(`SNH_HALF_CYC - 1) : div_r - 4'h1;
        unique case (st_r)
            snh_pkg::ST_IDLE: begin
                if (take && bad) begin
                    err_nxt = 1'h1;
                end
                if (poll_r || (take && !bad)) begin
                    st_nxt   = snh_pkg::ST_SHIFT;
                    ph_nxt   = snh_pkg::PH_CMD;
                    cs_n_nxt = 1'h0;
                    sclk_nxt = 1'h0;
                    ld_nxt   = 1'h0;
                    cnt_nxt  = 5'h08;
                    op_nxt   = sop;
                    sh_nxt   = {sop, 24'h000000};
                    div_nxt  = 4'(`SNH_HALF_CYC - 1);
                    addr_nxt = poll_r ? `SNH_STAT_ADR : cmd_addr;
                    len_nxt  = poll_r ? 12'h001 : cmd_len;
                end
                if (take && !bad) begin
                    wen_nxt  = cmd_op == `SNH_OP_WEN;
                    poll_nxt = cinf.bsy;
                    if (cmd_op == `SNH_OP_PEX) begin
                        lr_nxt  = cmd_addr[16:0];
                        lrv_nxt = 1'h1;
                    end
                    if (cmd_op == `SNH_OP_ERS && cmd_addr[16:`SNH_PG_W] == lr_r[16:`SNH_PG_W]) begin
                        lrv_nxt = 1'h0;
                    end
                end
            end
            snh_pkg::ST_SHIFT: begin
                if (tick && !sclk_r) begin
                    // rising edge: sample, count; stall if the buffer is full
                    if (!(ph_r == snh_pkg::PH_DATA && inf.rd && !poll_r && cnt_r == 5'h01
                          && !bif.in_ready)) begin
                        sclk_nxt = 1'h1;
                        if (ph_r == snh_pkg::PH_DATA && inf.rd) begin
                            unique case (inf.dwl)
                                2'h0:    rx_nxt = {rx_r[6:0], s2_r[1]};
                                2'h1:    rx_nxt = {rx_r[5:0], s2_r[1:0]};
                                default: rx_nxt = {rx_r[3:0], s2_r};
                            endcase
                        end
                        if (cnt_r != 5'h01) begin
                            cnt_nxt = cnt_r - 5'h01;
                        end else if (ph_r == snh_pkg::PH_DATA) begin
                            push     = inf.rd && !poll_r;
                            stat_nxt = (inf.rd && poll_r) ? rx_nxt : stat_r;
                            ld_nxt   = 1'h1;
                            cnt_nxt  = pclk(snh_pkg::PH_DATA, inf);
                            len_nxt  = len_r - 12'h001;
                            if (len_r == 12'h001) begin
                                ph_nxt = snh_pkg::PH_END;
                            end
                        end else begin
                            ph_nxt  = np;
                            cnt_nxt = pclk(np, inf);
                            ld_nxt  = 1'h1;
                        end
                    end
                end else if (tick) begin
                    // falling edge: present next bits; stall if no write byte
                    if (!(ld_r && ph_r == snh_pkg::PH_DATA && !inf.rd && !wr_valid)) begin
                        sclk_nxt = 1'h0;
                        ld_nxt   = 1'h0;
                        if (ph_r == snh_pkg::PH_END) begin
                            st_nxt  = snh_pkg::ST_CSHI;
                            gap_nxt = `SNH_GAP_TICKS;
                        end else if (ld_r && ph_r == snh_pkg::PH_ADDR) begin
                            sh_nxt = {addr_r << (5'h18 - inf.ab), 8'h00};
                        end else if (ld_r && ph_r == snh_pkg::PH_DATA) begin
                            wr_ready = !inf.rd;
                            sh_nxt   = {inf.rd ? 8'h00 : wr_data, 24'h000000};
                        end else if (ld_r) begin
                            sh_nxt = 32'h00000000;
                        end else begin
                            sh_nxt = sh_r << (3'h1 << wl);
                        end
                    end
                end
            end
            snh_pkg::ST_CSHI: begin
                // chip select high ends the frame, then a gap
                if (tick) begin
                    cs_n_nxt = 1'h1;
                    if (gap_r != 4'h0) begin
                        gap_nxt = gap_r - 4'h1;
                    end else begin
                        st_nxt = snh_pkg::ST_IDLE;
                        if (!poll_r) begin
                            done_nxt = 1'h1;
                        end else if (op_r == `SNH_OP_GETF && !stat_r[`SNH_OPERATION_IN_PROGRESS]) begin
                            poll_nxt = 1'h0;
                            done_nxt = 1'h1;
                        end
                    end
                end
            end
            default: st_nxt = snh_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= snh_pkg::ST_IDLE;
            ph_r   <= snh_pkg::PH_CMD;
            op_r   <= 8'h00;
            addr_r <= 24'h000000;
            len_r  <= 12'h000;
            cnt_r  <= 5'h00;
            sh_r   <= 32'h00000000;
            rx_r   <= 8'h00;
            stat_r <= 8'h00;
            gap_r  <= 4'h0;
            div_r  <= 4'h0;
            lr_r   <= 17'h00000;
            sclk_r <= 1'h0;
            cs_n_r <= 1'h1;
            ld_r   <= 1'h0;
            poll_r <= 1'h0;
            wen_r  <= 1'h0;
            lrv_r  <= 1'h0;
            done_r <= 1'h0;
            err_r  <= 1'h0;
            s1_r   <= 4'h0;
            s2_r   <= 4'h0;
        end else begin
            st_r   <= st_nxt;
            ph_r   <= ph_nxt;
            op_r   <= op_nxt;
            addr_r <= addr_nxt;
            len_r  <= len_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            rx_r   <= rx_nxt;
            stat_r <= stat_nxt;
            gap_r  <= gap_nxt;
            div_r  <= div_nxt;
            lr_r   <= lr_nxt;
            sclk_r <= sclk_nxt;
            cs_n_r <= cs_n_nxt;
            ld_r   <= ld_nxt;
            poll_r <= poll_nxt;
            wen_r  <= wen_nxt;
            lrv_r  <= lrv_nxt;
            done_r <= done_nxt;
            err_r  <= err_nxt;
            s1_r   <= io_i;
            s2_r   <= s1_r;
        end
    end

    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take(logic [7:0] o);
        cmd_valid && cmd_ready && cmd_op == o;
    endsequence
    property p_quad;
        take && cinf.qd && !quad_lines_enable |=> err && cs_n;
    endproperty
    a_quad: assert property (p_quad) else $error("quad command sent while quad lines off");
    property p_pex;
        s_take(`SNH_OP_PEX) ##0 !wen_r |=> err ##1 cs_n;
    endproperty
    a_pex: assert property (p_pex) else $error("execute sent without write enable");
    property p_ers;
        s_take(`SNH_OP_ERS) ##0 !wen_r |=> err && st_r == snh_pkg::ST_IDLE;
    endproperty
    a_ers: assert property (p_ers) else $error("erase sent without write enable");
    property p_ord;
        s_take(`SNH_OP_PEX) ##0 ord_bad |=> err;
    endproperty
    a_ord: assert property (p_ord) else $error("page programmed out of order");
    property p_col;
        take && cinf.ab == 5'h10 && cmd_addr[11:0] > `SNH_COL_MAX |=> err;
    endproperty
    a_col: assert property (p_col) else $error("column beyond cache end sent");
    property p_cshi;
        $rose(cs_n) |-> $past(ph_r) == snh_pkg::PH_END && !sclk;
    endproperty
    a_cshi: assert property (p_cshi) else $error("frame closed before its end");
    property p_poll;
        $rose(cs_n) && poll_r && (op_r != `SNH_OP_GETF || stat_r[0]) |-> ##[1:100] $fell(cs_n);
    endproperty
    a_poll: assert property (p_poll) else $error("status poll not repeated while busy");
    property p_dual;
        st_r == snh_pkg::ST_SHIFT && ph_r == snh_pkg::PH_ADDR && op_r == `SNH_OP_RDCD
            |-> io_oe_n == 4'h0 && cnt_r <= 5'h08;
    endproperty
    a_dual: assert property (p_dual) else $error("dual address not on two lines");
    property p_qio;
        st_r == snh_pkg::ST_SHIFT && ph_r == snh_pkg::PH_ADDR && op_r == `SNH_OP_RDCQ
            |-> io_oe_n == 4'h0 && cnt_r <= 5'h04;
    endproperty
    a_qio: assert property (p_qio) else $error("quad address not on four lines");
    property p_cmd;
        st_r == snh_pkg::ST_SHIFT && ph_r == snh_pkg::PH_CMD |-> io_oe_n == 4'h2 && !cs_n;
    endproperty
    a_cmd: assert property (p_cmd) else $error("opcode not on line zero");
endmodule

// ---- sim/snh_dev_model.sv ----
module snh_dev_model (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic [3:0] io_o,
    input  wire logic [3:0] io_oe_n,
    output logic [3:0]      io_i
);
    timeunit 1ns;
    timeprecision 1ps;
    parameter logic [15:0] ID = 16'h5A3C; // arbitrary identity bytes
    parameter logic [63:0] SERIAL = 64'h0000000000000000; // arbitrary factory number
    logic [7:0]  op, st, c [0:2111];
    logic [31:0] sh;
    logic        d1 = 1'b0, write_enable_latch = 1'b0;
    int          n, col, a0, busy = 0;
    assign st = {6'h00, write_enable_latch, busy != 0};
    // released lines show the inverse of the host value, io1 the device bit
    always_comb for (int k = 0; k < 4; k++) io_i[k] = io_oe_n[k] ? (k == 1 ? d1 : ~io_o[k]) : io_o[k];
    always @(negedge cs_n) n = 0;
    // frame end: latch, busy countdown per status poll
    always @(posedge cs_n) begin
        d1 = ~d1;
        if (op == 8'h06) write_enable_latch = 1'b1;
        if (op == 8'h04) write_enable_latch = 1'b0;
        if (op == 8'h0F && busy == 1) write_enable_latch = 1'b0;
        if (op == 8'h0F && busy > 0) busy--;
        if (op == 8'hFF) busy = 0;
    end
    // host bits sampled on the rising clock
    always @(posedge sclk) if (!cs_n) begin
        sh = {sh[30:0], io_o[0]};
        n++;
        if (n == 8) op = sh[7:0];
        if (n == 24) col = sh[11:0];
        if (n == 24) a0 = col;
        if (n > 24 && n % 8 == 0 && (op == 8'h02 || op == 8'h84) && col < 2112) begin
            c[col] = sh[7:0];
            col++;
        end
        if (n == 32 && (op == 8'hD8 || op == 8'h10) && write_enable_latch && busy == 0) busy = 3;
    end
    // device bits shifted on the falling clock
    always @(negedge sclk) if (!cs_n) begin
        if (op == 8'h9F && n >= 16 && n < 32) d1 = ID[31 - n];
        if (op == 8'h4B && n >= 40 && n < 104) d1 = SERIAL[103 - n];
        if (op == 8'h0F && n >= 16) d1 = st[7 - n % 8];
        if (op == 8'h03 && n >= 32) d1 = c[(a0 + (n - 32) / 8) % 2112][7 - n % 8];
    end
endmodule

// ---- sim/spi_nand_cache_program_erase_test.sv ----
module spi_nand_cache_program_erase_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, rst_n = 0, cmd_valid = 0, quad_lines_enable = 0, wr_valid = 0, rd_ready = 0;
    logic [7:0]  cmd_op = 8'h00, wr_data = 8'h00, rd_data, status, d [6];
    logic [23:0] cmd_addr = 24'h000000;
    logic [11:0] cmd_len = 12'h000;
    logic        cmd_ready, wr_ready, rd_valid, done, err, sclk, cs_n;
    logic [3:0]  io_o, io_oe_n, io_i;
    logic [7:0]  wq [$], eq [$];
    int          fails = 0, n_compared = 0;
    localparam logic [63:0] SER = 64'hC3A596E10F78B42D; // arbitrary factory number
    always #2.5 sys_clk = ~sys_clk;
    snh_ctrl snh_ctrl_i (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_len, .quad_lines_enable,
        .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .done, .err, .status, .sclk, .cs_n,
        .io_o, .io_oe_n, .io_i);
    snh_dev_model #(.SERIAL(SER)) snh_dev_model_i (.sclk, .cs_n, .io_o, .io_oe_n, .io_i);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // load bytes fed in order, read bytes drained with random stalls
    always @(posedge sys_clk) begin
        if (wr_ready) void'(wq.pop_front());
        wr_valid <= wq.size() > 0;
        wr_data <= wq.size() > 0 ? wq[0] : 8'h00;
        rd_ready <= 1'($urandom % 2);
        if (rd_valid && rd_ready) chk(rd_data, eq.pop_front());
    end
    // one command, then wait for its done or err pulse
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [11:0] len, input logic e);
        int k;
        @(posedge sys_clk);
        while (!cmd_ready) @(posedge sys_clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= len;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        for (k = 0; k < 9000 && !(done || err); k++) @(negedge sys_clk);
        chk({done, err}, {!e, e});
    endtask
    initial begin
        void'($urandom(25));
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (3) @(posedge sys_clk);
        chk({cs_n, io_oe_n, status}, {1'b1, 4'hF, 8'h00});
        rst_n <= 1'b1;
        cmd(8'h6B, 24'h000000, 12'h004, 1'b1);
        cmd(8'hD8, 24'h000040, 12'h000, 1'b1);
        eq = {8'h5A, 8'h3C};
        cmd(8'h9F, 24'h000000, 12'h002, 1'b0);
        wq = {d[0], d[1]};
        cmd(8'h02, 24'h000000, 12'h002, 1'b0);
        wq = {d[2], d[3], d[4], d[5]};
        cmd(8'h84, 24'h00083E, 12'h004, 1'b0);
        eq = {d[2], d[3], d[0], d[1]};
        cmd(8'h03, 24'h00083E, 12'h004, 1'b0);
        cmd(8'h06, 24'h000000, 12'h000, 1'b0);
        cmd(8'hD8, 24'h000040, 12'h000, 1'b0);
        chk(status, 8'h00);
        cmd(8'h10, 24'h000040, 12'h000, 1'b1);
        cmd(8'h03, 24'h000840, 12'h001, 1'b1);
        cmd(8'h06, 24'h000000, 12'h000, 1'b0);
        cmd(8'h10, 24'h000040, 12'h000, 1'b0);
        chk(status, 8'h00);
        cmd(8'h06, 24'h000000, 12'h000, 1'b0);
        cmd(8'h10, 24'h000040, 12'h000, 1'b1);
        cmd(8'h04, 24'h000000, 12'h000, 1'b0);
        cmd(8'hFF, 24'h000000, 12'h000, 1'b0);
        chk(status, 8'h00);
        for (int i = 7; i >= 0; i--) eq.push_back(SER[8*i+:8]);
        cmd(8'h4B, 24'h000000, 12'h008, 1'b0);
        cmd(8'hBB, 24'h000000, 12'h000, 1'b0);
        @(posedge sys_clk);
        quad_lines_enable <= 1'b1;
        cmd(8'hEB, 24'h000000, 12'h000, 1'b0);
        repeat (20) @(posedge sys_clk);
        chk(eq.size(), 0);
        summarize;
    end
    initial begin
        #200000;
        fails++;
        summarize;
    end
endmodule
